/* File: hdl/dwb_pkg.sv */
// dwb_pkg: constants, register map and carrier types of the write burst path
// assumes a 32-bit AHB-Lite register bus and a 16-bit data lane pair on the memory pins
package dwb_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_MODE      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_MEM_INDEX = 8'h08;
    localparam logic [7:0] OFS_MEM_DATA  = 8'h0c;

    // mode_reg field positions
    localparam int CAS_LSB = 0;
    localparam int BL8_BIT = 3;
    localparam int AL_LSB  = 4;
    localparam int WR_LSB  = 9;

    // mode_reg reset values
    localparam logic [2:0] CAS_RST = 3'h3;
    localparam logic [2:0] AL_RST  = 3'h0;
    localparam logic       BL8_RST = 1'b0;
    localparam logic [2:0] WR_RST  = 3'h3;

    // status field positions
    localparam int ST_CUR_BIT   = 4;
    localparam int ST_NXT_BIT   = 5;
    localparam int ST_REC_BIT   = 6;
    localparam int ST_COUNT_LSB = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // burst geometry
    localparam logic [3:0] BURST_SHORT   = 4'h4;
    localparam logic [3:0] BURST_LONG    = 4'h8;
    localparam logic [3:0] INTERRUPT_GAP = 4'h2;
    localparam int         BANKS         = 4;
    localparam int         LANES         = 2;
    localparam int         MEM_DEPTH     = 16;
    localparam int         AP_BIT        = 10;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // memory pins as one group, strobe[0] / dm[0] / dq[7:0] are the lower byte
    typedef struct packed {
        logic        ck;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  bank;
        logic [13:0] addr;
        logic [1:0]  strobe;
        logic [15:0] dq;
        logic [1:0]  dm;
    } dwb_pin_type;

    // one accepted write burst
    typedef struct packed {
        logic       valid;
        logic       ap;
        logic       bl8;
        logic [1:0] bank;
        logic [3:0] col;
        logic [3:0] edges;
        logic       armed;
        logic [3:0] limit;
    } dwb_slot_type;

    typedef struct packed {
        logic [2:0] wr;
        logic [2:0] al;
        logic       bl8;
        logic [2:0] cas;
    } dwb_mode_type;

endpackage : dwb_pkg

/* File: hdl/dwb_write_path.sv */
// dwb_write_path: write burst path of a DDR2 memory with an AHB-Lite register slave
// assumes all memory pins come from outside the clk domain; ck is slow enough to sample
//
// Contract
// - write latency equals read latency (cas plus additive) minus one clock
// - write with auto precharge closes its row after burst and recovery
// - first element on first rising strobe, later elements on every strobe edge
// - after a burst with nothing pending, data pins stay undriven, input ignored
// - burst of eight without auto precharge truncated only by write at four
// - interrupting write may use any bank, row and auto precharge choice
// - auto precharge select bit low disables, high enables auto precharge
// - lower byte strobe times lower byte, upper byte strobe times upper byte
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module dwb_write_path
    import dwb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        ck,
    input  wire logic        chip_sel_n,
    input  wire logic        row_strobe_n,
    input  wire logic        col_strobe_n,
    input  wire logic        write_en_n,
    input  wire logic [1:0]  bank_addr,
    input  wire logic [13:0] addr,
    input  wire logic        lower_byte_strobe,
    input  wire logic        upper_byte_strobe,
    input  wire logic [15:0] dq_in,
    input  wire logic [1:0]  data_mask_input,
    output logic [15:0]      dq_out,
    output logic [15:0]      dq_oe_n
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, the second stage feeds everything
    dwb_pin_type pin_raw, sync1_reg, sync2_reg;
    logic        ck_d_reg;
    logic [1:0]  strobe_d_reg;

    assign pin_raw = '{ck, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, bank_addr,
                       addr, {upper_byte_strobe, lower_byte_strobe}, dq_in, data_mask_input};

    always_ff @(posedge clk) begin
        sync1_reg    <= pin_raw;
        sync2_reg    <= sync1_reg;
        ck_d_reg     <= rst ? 1'b0 : sync2_reg.ck;
        strobe_d_reg <= rst ? 2'h0 : sync2_reg.strobe;
    end

    // command decode on each detected ck rise
    logic       ck_rise, cmd_write, cmd_activate;
    logic [3:0] wl_m1;
    dwb_mode_type mode_reg, mode_next;

    assign ck_rise      = sync2_reg.ck & ~ck_d_reg;
    assign cmd_write    = ck_rise & ~sync2_reg.cs_n & sync2_reg.ras_n & ~sync2_reg.cas_n
                          & ~sync2_reg.we_n;
    assign cmd_activate = ck_rise & ~sync2_reg.cs_n & ~sync2_reg.ras_n & sync2_reg.cas_n
                          & sync2_reg.we_n;
    assign wl_m1 = 4'({1'b0, mode_reg.cas} + {1'b0, mode_reg.al}) - 4'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // burst slots: current burst and one queued or interrupting burst
    dwb_slot_type cur_reg, cur_next, nxt_reg, nxt_next, new_slot;
    logic [3:0]   cnt_reg [LANES];
    logic [3:0]   cnt_next [LANES];
    logic [LANES-1:0] cap, lane_we;
    logic         done, trunc;
    logic [7:0]   bursts_reg, bursts_next;

    assign done = cur_reg.valid && cnt_reg[0] == cur_reg.limit && cnt_reg[1] == cur_reg.limit;
    assign new_slot = '{valid: 1'b1, ap: sync2_reg.addr[AP_BIT], bl8: mode_reg.bl8,
                        bank: sync2_reg.bank, col: sync2_reg.addr[3:0], edges: 4'h0,
                        armed: wl_m1 == 4'h0,
                        limit: mode_reg.bl8 ? BURST_LONG : BURST_SHORT};

    // slot sequencing: age, retire, accept
    always_comb begin
        cur_next    = cur_reg;
        nxt_next    = nxt_reg;
        bursts_next = bursts_reg;
        trunc       = 1'b0;
        if (ck_rise) begin
            if (cur_next.valid && !cur_next.armed) begin
                cur_next.edges = cur_next.edges + 4'h1;
                cur_next.armed = cur_next.edges == wl_m1;
            end else if (cur_next.valid) begin
                cur_next.edges = cur_next.edges + 4'h1;
            end
            if (nxt_next.valid && !nxt_next.armed) begin
                nxt_next.edges = nxt_next.edges + 4'h1;
                nxt_next.armed = nxt_next.edges == wl_m1;
            end
        end
        if (done) begin
            cur_next       = nxt_next;
            nxt_next.valid = 1'b0;
            bursts_next    = bursts_reg + 8'h1;
        end
        if (cmd_write) begin
            if (!cur_next.valid) begin
                cur_next = new_slot;
            end else if (!nxt_next.valid) begin
                // long burst without auto precharge, hit two clocks in: cut at four
                if (cur_next.bl8 && !cur_next.ap && cur_next.edges == INTERRUPT_GAP
                    && cnt_reg[0] <= BURST_SHORT && cnt_reg[1] <= BURST_SHORT) begin
                    cur_next.limit = BURST_SHORT;
                    trunc          = 1'b1;
                end
                nxt_next = new_slot;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur_reg    <= '0;
            nxt_reg    <= '0;
            bursts_reg <= 8'h0;
        end else begin
            cur_reg    <= cur_next;
            nxt_reg    <= nxt_next;
            bursts_reg <= bursts_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per byte lane capture into the array
    logic [7:0] mem_reg [LANES][MEM_DEPTH];
    logic [3:0] mem_index_reg, mem_index_next;

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic rise, edge_any;
        assign rise     = sync2_reg.strobe[l] & ~strobe_d_reg[l];
        assign edge_any = sync2_reg.strobe[l] ^ strobe_d_reg[l];
        // own strobe only, first element needs a rising edge
        assign cap[l] = cur_reg.valid && cur_reg.armed && cnt_reg[l] < cur_reg.limit
                        && (cnt_reg[l] == 4'h0 ? rise : edge_any);
        assign lane_we[l] = cap[l] & ~sync2_reg.dm[l];

        always_comb begin
            cnt_next[l] = cnt_reg[l];
            if (done) begin
                cnt_next[l] = 4'h0;
            end else if (cap[l]) begin
                cnt_next[l] = cnt_reg[l] + 4'h1;
            end
        end

        always_ff @(posedge clk) begin
            cnt_reg[l] <= rst ? 4'h0 : cnt_next[l];
            if (lane_we[l]) begin
                mem_reg[l][cur_reg.col + cnt_reg[l]] <= sync2_reg.dq[8*l +: 8];
            end
        end
    end

    // data pins are input only in this path
    assign dq_out  = 16'h0000;
    assign dq_oe_n = 16'hffff;

    ////////////////////////////////////////////////////////////////////////////////
    // per bank row state and auto precharge recovery countdown
    logic [BANKS-1:0] bank_open, rec_busy, pre_fire;

    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        logic       open_reg, open_next, busy_reg, busy_next;
        logic [2:0] rec_reg, rec_next;
        assign pre_fire[b] = busy_reg && ck_rise && rec_reg <= 3'h1;

        always_comb begin
            open_next = open_reg;
            busy_next = busy_reg;
            rec_next  = rec_reg;
            if (busy_reg && ck_rise) begin
                rec_next = rec_reg - 3'h1;
            end
            if (pre_fire[b]) begin
                busy_next = 1'b0;
                open_next = 1'b0;
            end
            if (done && cur_reg.ap && cur_reg.bank == 2'(b)) begin
                busy_next = 1'b1;
                rec_next  = mode_reg.wr;
            end
            if (cmd_activate && sync2_reg.bank == 2'(b)) begin
                open_next = 1'b1;
            end
        end

        always_ff @(posedge clk) begin
            open_reg <= rst ? 1'b0 : open_next;
            busy_reg <= rst ? 1'b0 : busy_next;
            rec_reg  <= rst ? 3'h0 : rec_next;
        end

        assign bank_open[b] = open_reg;
        assign rec_busy[b]  = busy_reg;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, read data registered in the address phase
    logic        ahb_go, wpend_reg, wpend_next;
    logic [7:0]  waddr_reg, waddr_next;
    logic [31:0] rd_mux, hrdata_reg, hrdata_next;

    assign ahb_go    = hsel && hready && htrans == HTRANS_NONSEQ;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    // register read decode, unmapped reads return zero
    always_comb begin
        rd_mux = 32'h0;
        unique case (haddr[7:0])
            OFS_MODE: begin
                rd_mux[CAS_LSB +: 3] = mode_reg.cas;
                rd_mux[BL8_BIT]      = mode_reg.bl8;
                rd_mux[AL_LSB +: 3]  = mode_reg.al;
                rd_mux[WR_LSB +: 3]  = mode_reg.wr;
            end
            OFS_STATUS: begin
                rd_mux[BANKS-1:0]         = bank_open;
                rd_mux[ST_CUR_BIT]        = cur_reg.valid;
                rd_mux[ST_NXT_BIT]        = nxt_reg.valid;
                rd_mux[ST_REC_BIT]        = |rec_busy;
                rd_mux[ST_COUNT_LSB +: 8] = bursts_reg;
            end
            OFS_MEM_INDEX: rd_mux[3:0] = mem_index_reg;
            OFS_MEM_DATA:  rd_mux[15:0] = {mem_reg[1][mem_index_reg], mem_reg[0][mem_index_reg]};
            default:       rd_mux = 32'h0;
        endcase
    end

    // bus next state: latch write address, apply write data in data phase
    always_comb begin
        wpend_next     = ahb_go && hwrite;
        waddr_next     = haddr[7:0];
        hrdata_next    = (ahb_go && !hwrite) ? rd_mux : hrdata_reg;
        mode_next      = mode_reg;
        mem_index_next = mem_index_reg;
        if (wpend_reg && waddr_reg == OFS_MODE) begin
            mode_next = '{wr: hwdata[WR_LSB +: 3], al: hwdata[AL_LSB +: 3],
                          bl8: hwdata[BL8_BIT], cas: hwdata[CAS_LSB +: 3]};
        end
        if (wpend_reg && waddr_reg == OFS_MEM_INDEX) begin
            mem_index_next = hwdata[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wpend_reg     <= 1'b0;
            waddr_reg     <= 8'h0;
            hrdata_reg    <= 32'h0;
            mode_reg      <= '{wr: WR_RST, al: AL_RST, bl8: BL8_RST, cas: CAS_RST};
            mem_index_reg <= 4'h0;
        end else begin
            wpend_reg     <= wpend_next;
            waddr_reg     <= waddr_next;
            hrdata_reg    <= hrdata_next;
            mode_reg      <= mode_next;
            mem_index_reg <= mem_index_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks next to the logic they guard
    a_latency_arm: assert property ($rose(cur_reg.armed) && $past(cur_reg.valid)
        |-> cur_reg.edges == wl_m1) else $error("burst armed at wrong latency");
    a_first_rise: assert property (cap[0] && cnt_reg[0] == 4'h0
        |-> sync2_reg.strobe[0] && !strobe_d_reg[0])
        else $error("first element not on rising strobe");
    a_idle_ignore: assert property (!cur_reg.valid |-> lane_we == 2'h0)
        else $error("data written with no burst");
    a_short_whole: assert property (cur_reg.valid && !cur_reg.bl8
        |-> cur_reg.limit == BURST_SHORT) else $error("short burst cut");
    a_trunc_only: assert property (trunc |=> cur_reg.limit == BURST_SHORT && nxt_reg.valid
        && !$past(cur_reg.ap)) else $error("bad truncation");
    a_ap_close: assert property (|pre_fire |=> (bank_open & $past(pre_fire)) == '0)
        else $error("auto precharge left row open");
    a_ap_select: assert property (cmd_write && !cur_reg.valid && !done
        |=> cur_reg.ap == $past(sync2_reg.addr[AP_BIT]))
        else $error("auto precharge bit lost");
    a_mask_skip: assert property (cap[1] && sync2_reg.dm[1] |-> !lane_we[1])
        else $error("masked element written");
    a_lane_split: assert property (cap[1] |-> sync2_reg.strobe[1] != strobe_d_reg[1])
        else $error("upper byte captured without its strobe");
    a_rec_start: assert property (done && cur_reg.ap |=> rec_busy != '0)
        else $error("recovery not started");

    c_burst_done: cover property (done);
    c_truncate:   cover property (trunc);
    c_precharge:  cover property (|pre_fire);
    c_concat:     cover property (done && nxt_reg.valid);

endmodule : dwb_write_path

/* File: sim/dwb_host_model.sv */
// dwb_host_model: behavioural memory controller driving the write side of the memory pins
// assumes the bench calls cmd at a falling ck edge and passes the write latency it programmed
`timescale 1ns/1ps
module dwb_host_model
    import dwb_pkg::*;
(
    output logic        ck,
    output logic        chip_sel_n,
    output logic        row_strobe_n,
    output logic        col_strobe_n,
    output logic        write_en_n,
    output logic [1:0]  bank_addr,
    output logic [13:0] addr,
    output logic        lower_byte_strobe,
    output logic        upper_byte_strobe,
    output logic [15:0] dq_in,
    output logic [1:0]  data_mask_input
);
    //////////////////////////////////////////////////
    // free-running memory clock, phase unrelated to clk
    initial begin
        ck = 1'b0;
        #17;
        forever #400 ck = ~ck;
    end

    // idle pins: deselected, strobes low
    // no read or precharge is ever issued, so their spacing holds trivially
    // there is no clock enable pin here: the access is never suspended
    initial begin
        {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n} = 4'hf;
        {bank_addr, addr, dq_in, data_mask_input} = '0;
        {lower_byte_strobe, upper_byte_strobe} = 2'b00;
    end

    //////////////////////////////////////////////////
    // one command held across one rising ck edge, then released
    task automatic cmd(input logic [2:0] rcw, input logic [1:0] b, input logic [13:0] a);
        {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n} <= {1'b0, rcw};
        bank_addr <= b;
        addr      <= a;
        @(posedge ck);
        @(negedge ck);
        {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n} <= 4'hf;
        bank_addr <= ~b;  // released lines never show a stale value
        addr      <= ~a;
    endtask : cmd

    // data stream: strobe edges on ck edges, data placed a quarter period ahead
    task automatic stream(input int wl, input int n, input logic [15:0] base,
                          input logic [15:0] mlo, input logic [15:0] mhi);
        logic [15:0] d;
        #(wl * 800 - 600);  // strobe stays low through the preamble
        for (int k = 0; k < n; k++) begin
            d = base + 16'(k) * 16'h0101;
            dq_in           <= d;
            data_mask_input <= {mhi[k], mlo[k]};
            #200;
            lower_byte_strobe <= ~lower_byte_strobe;  // nominal edge on ck
            upper_byte_strobe <= ~upper_byte_strobe;
            #200;
        end
        dq_in           <= ~dq_in;  // strobes end low, postamble
        data_mask_input <= ~data_mask_input;
    endtask : stream
endmodule : dwb_host_model

/* File: sim/tb.sv */
// tb: register-bus and memory-pin tests of the write burst path
// assumes dwb_host_model drives the memory pins and hready follows hreadyout
`timescale 1ns/1ps
module tb
    import dwb_pkg::*;
;
    logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, bank_addr, data_mask_input;
    logic [2:0]  hsize;
    logic        ck, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n;
    logic        lower_byte_strobe, upper_byte_strobe;
    logic [13:0] addr;
    logic [15:0] dq_in, dq_out, dq_oe_n;
    logic [15:0] shadow [16];
    int          err_total = 0;
    int          n_tests = 0;

    assign hready = hreadyout;

    dwb_write_path i_dwb_write_path (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ck(ck),
        .chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
        .write_en_n(write_en_n), .bank_addr(bank_addr), .addr(addr),
        .lower_byte_strobe(lower_byte_strobe), .upper_byte_strobe(upper_byte_strobe),
        .dq_in(dq_in), .data_mask_input(data_mask_input), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

    dwb_host_model i_dwb_host_model (.ck(ck), .chip_sel_n(chip_sel_n),
        .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_en_n(write_en_n),
        .bank_addr(bank_addr), .addr(addr), .lower_byte_strobe(lower_byte_strobe),
        .upper_byte_strobe(upper_byte_strobe), .dq_in(dq_in),
        .data_mask_input(data_mask_input));

    //////////////////////////////////////////////////
    // system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // counts and verdict
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run

    //////////////////////////////////////////////////
    // one single ahb-lite transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    // read a register and compare the masked value
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(r & m, exp);
    endtask : rd_chk

    // write command with column, bank and auto precharge select
    task automatic wr_cmd(input logic [3:0] col, input logic [1:0] b, input logic ap);
        i_dwb_host_model.cmd(3'b100, b, {3'h0, ap, 6'h0, col});
    endtask : wr_cmd

    // expected array contents after a stream slice
    task automatic apply(input int col, input int n, input int k0, input logic [15:0] base,
                         input logic [15:0] mlo, input logic [15:0] mhi);
        logic [15:0] d;
        for (int i = 0; i < n; i++) begin
            d = base + 16'(k0 + i) * 16'h0101;
            if (!mlo[k0 + i]) shadow[(col + i) % 16][7:0] = d[7:0];  // masked byte kept
            if (!mhi[k0 + i]) shadow[(col + i) % 16][15:8] = d[15:8];
        end
    endtask : apply

    // read back every known array word
    task automatic mem_verify(input string name);
        logic [31:0] r;
        for (int i = 0; i < MEM_DEPTH; i++) begin
            if (^shadow[i] !== 1'bx) begin
                bus(1'b1, OFS_MEM_INDEX, 32'(i), r);
                rd_chk(OFS_MEM_DATA, 32'hffff, {16'h0, shadow[i]});
            end
        end
        $display("test %s finished, mismatches so far %0d", name, err_total);
    endtask : mem_verify

    //////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [31:0] r;
        {rst, hsel, hwrite} = 3'b100;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_chk(OFS_MODE, '1, 32'h0000_0603);
        rd_chk(OFS_STATUS, '1, 32'h0);
        rd_chk(8'h10, '1, 32'h0);
        check({16'h0, dq_oe_n}, 32'h0000_ffff);
        // single burst of four, then stray strobes with no command
        @(negedge ck);
        i_dwb_host_model.cmd(3'b011, 2'h0, 14'h0);
        i_dwb_host_model.cmd(3'b011, 2'h1, 14'h0);
        wr_cmd(4'h0, 2'h0, 1'b0);
        i_dwb_host_model.stream(2, 4, 16'h1100, 16'h0, 16'h0);
        apply(0, 4, 0, 16'h1100, 16'h0, 16'h0);
        i_dwb_host_model.stream(1, 4, 16'h9900, 16'h0, 16'h0);  // ignored
        mem_verify("single");
        // gapless bursts of four with masked elements
        @(negedge ck);
        wr_cmd(4'hc, 2'h0, 1'b0);
        fork
            i_dwb_host_model.stream(2, 8, 16'h2200, 16'h0020, 16'h0040);
            begin
                @(negedge ck);
                wr_cmd(4'h0, 2'h0, 1'b0);
            end
        join
        apply(12, 4, 0, 16'h2200, 16'h0020, 16'h0040);
        apply(0, 4, 4, 16'h2200, 16'h0020, 16'h0040);
        repeat (4) @(posedge clk);  // last strobe edge still crossing the synchroniser
        rd_chk(OFS_STATUS, 32'hff30, 32'h0300);  // both complete
        mem_verify("gapless");
        // burst of eight with additive latency one
        bus(1'b1, OFS_MODE, 32'h0000_061b, r);
        rd_chk(OFS_MODE, '1, 32'h0000_061b);
        @(negedge ck);
        wr_cmd(4'h4, 2'h0, 1'b0);
        i_dwb_host_model.stream(3, 8, 16'h3300, 16'h0, 16'h0);
        apply(4, 8, 0, 16'h3300, 16'h0, 16'h0);
        mem_verify("eight");
        // burst of eight cut by a write two clocks later to another bank
        @(negedge ck);
        wr_cmd(4'h8, 2'h0, 1'b0);
        fork
            i_dwb_host_model.stream(3, 12, 16'h4400, 16'h0, 16'h0);
            begin
                @(negedge ck);
                wr_cmd(4'h0, 2'h1, 1'b0);
            end
        join
        apply(8, 4, 0, 16'h4400, 16'h0, 16'h0);
        apply(0, 8, 4, 16'h4400, 16'h0, 16'h0);
        mem_verify("interrupt");
        // auto precharge closes bank one after recovery
        bus(1'b1, OFS_MODE, 32'h0000_0603, r);
        @(negedge ck);
        wr_cmd(4'h0, 2'h1, 1'b1);
        i_dwb_host_model.stream(2, 4, 16'h5500, 16'h0, 16'h0);
        apply(0, 4, 0, 16'h5500, 16'h0, 16'h0);
        repeat (4) @(posedge clk);  // let the burst retire before looking
        rd_chk(OFS_STATUS, 32'h5f, 32'h43);  // recovery running
        repeat (40) @(posedge clk);
        rd_chk(OFS_STATUS, 32'h5f, 32'h01);  // bank one closed
        mem_verify("autoprecharge");
        complete_run();
    end

    // watchdog against a hang
    initial begin
        #1_000_000;
        err_total++;
        complete_run();
    end
endmodule : tb
